/* common/tlic_consts.vh */
// register offsets, field positions, vector layout and timing counts for the interrupt controller
`ifndef TLIC_CONSTS_VH
`define TLIC_CONSTS_VH

`define TLIC_OFF_MASK 8'hA8
`define TLIC_OFF_LEVEL 8'hB8
`define TLIC_OFF_XMASK_A 8'hE6
`define TLIC_OFF_XLEVEL_A 8'hF6
`define TLIC_OFF_XMASK_B 8'hE7
`define TLIC_OFF_XLEVEL_B 8'hF7
`define TLIC_OFF_PEND_LO 8'hC0
`define TLIC_OFF_PEND_HI 8'hC1
`define TLIC_OFF_PEND_X 8'hC2
`define TLIC_OFF_STATUS 8'hC3

`define TLIC_MASK_RESET 8'h00
`define TLIC_LEVEL_RESET 8'h00
`define TLIC_GATE_BIT 7
`define TLIC_T2_ORDER 5
`define TLIC_NSRC 17
`define TLIC_SRC_USED 17'h17EFF

`define TLIC_VEC_BASE 16'h0003
`define TLIC_VEC_STEP 4'h8
`define TLIC_DETECT_CYC 1
`define TLIC_CALL_CYC 3'h4

`endif

/* hw/tlic_arbiter.v */
// fixed-order priority encoder picking the lowest-numbered active request
`timescale 1ns/1ps
`default_nettype none
`include "tlic_consts.vh"

module tlic_arbiter (
	// requests by order number
	input wire [16:0] req,
	// result
	output reg hit,
	output reg [4:0] idx
);
	integer i;

	always @* begin
		hit = 1'b0;
		idx = 5'h00;
		// walk down so the smallest order number wins
		for (i = `TLIC_NSRC - 1; i >= 0; i = i - 1) begin
			if (req[i]) begin
				hit = 1'b1;
				idx = i[4:0];
			end
		end
	end
endmodule
`default_nettype wire

/* hw/tlic_top.v */
// two-level interrupt controller: masks, levels, arbitration, vectoring
//
// Added by the designer: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "tlic_consts.vh"

// How it works
// - each source picks low or high level; high may preempt a low routine
// - while a high routine runs, nothing else is vectored
// - all level bits reset to low
// - high level wins, then smallest order number among equals
// - pending requests sampled and decoded every clock
// - best case five clocks: one detect, four to finish the call
// - a program fetch stall lengthens the response by its cycles
// - request pending at return: one more instruction before the call
// - equal or lower request waits for return plus one instruction
// - vectors eight bytes apart from 0x0003 to 0x0083; 8 and 15 unused
// - only pin and basic timer flags self-clear on vectoring
// - every source has a level bit in one of three level registers
// - bit 7 gate overrides every mask; zero blocks all
// - base mask bits 6..0 select sources six down to zero
// - timer 2 requests on either its low or high overflow flag
// - later sources use extended registers a bits 0,2-7 and b bit 1
// - enable register is 8 bits at 0xA8, resets to zero
// - flags set while disabled; request needs gate and mask
// - flag still set after return requests again after next instruction
// - software-set flag vectors like a hardware one
module tlic_top (
	// clock and reset
	input wire SYS_CLK,
	input wire RST_N,
	// register port
	input wire [7:0] REG_ADDR,
	input wire [7:0] REG_WDATA,
	input wire REG_WR,
	input wire REG_RD,
	output reg [7:0] REG_RDATA,
	// source conditions, one-cycle pulses by order number
	input wire [16:0] SRC_EVENT,
	input wire T2_LOW_OVF,
	input wire T2_HIGH_OVF,
	// core sequencer handshake
	input wire INSTR_DONE,
	input wire RETURN_DONE,
	input wire FETCH_STALL,
	// call to the core
	output reg CALL_REQ,
	output reg [15:0] CALL_ADDR,
	output reg CALL_TAKEN,
	output reg [1:0] IN_SERVICE
);
	// ------------------------------------------------------------
	// states
	// ------------------------------------------------------------
	localparam [3:0] ST_IDLE = 4'b0001;
	localparam [3:0] ST_CALL = 4'b0010;
	localparam [3:0] ST_HOLD = 4'b0100;
	localparam [3:0] ST_WAIT = 4'b1000;
	localparam [16:0] AUTO_CLR = 17'h0000F;
	// reserved orders 8 and 15 have no source behind them
	localparam [16:0] SRC_USED = `TLIC_SRC_USED;
	localparam [2:0] CALL_LAST = `TLIC_CALL_CYC - 3'h1;

	reg [7:0] mask_ff;
	reg [6:0] level_ff;
	reg [7:0] xmask_a_ff;
	reg [7:0] xlevel_a_ff;
	reg xmask_b_ff;
	reg xlevel_b_ff;
	reg [16:0] pend_ff;
	reg t2_low_ff;
	reg t2_high_ff;
	reg [1:0] insvc_ff;
	reg [3:0] state_ff;
	reg [2:0] cnt_ff;
	reg [4:0] sel_ff;
	reg sel_high_ff;
	reg hold_ff;

	reg [3:0] nxt_state;
	reg [2:0] nxt_cnt;
	reg [7:0] nxt_rdata;
	reg [1:0] nxt_insvc;

	wire [16:0] mask_vec;
	wire [16:0] lvl_vec;
	wire [16:0] pend_eff;
	wire [16:0] req_vec;
	wire [16:0] req_hi;
	wire [16:0] req_lo;
	wire hit_hi;
	wire hit_lo;
	wire [4:0] idx_hi;
	wire [4:0] idx_lo;
	wire allow_hi;
	wire allow_lo;
	wire take;
	wire [4:0] take_idx;
	wire take_high;

	// ------------------------------------------------------------
	// mask and level maps by order number
	// ------------------------------------------------------------
	assign mask_vec = {xmask_b_ff, 1'b0, xmask_a_ff[7:2], 1'b0, xmask_a_ff[0],
		mask_ff[6:0]};
	assign lvl_vec = {xlevel_b_ff, 1'b0, xlevel_a_ff[7:2], 1'b0, xlevel_a_ff[0],
		level_ff};

	// timer 2 source is the or of its two overflow flags
	assign pend_eff = {pend_ff[16:6], t2_low_ff | t2_high_ff, pend_ff[4:0]};

	// gate overrides all masks; pending stays held meanwhile
	assign req_vec = pend_eff & mask_vec & `TLIC_SRC_USED
		& {`TLIC_NSRC{mask_ff[`TLIC_GATE_BIT]}};
	assign req_hi = req_vec & lvl_vec;
	assign req_lo = req_vec & ~lvl_vec;

	tlic_arbiter u_arb_hi (
		.req(req_hi),
		.hit(hit_hi),
		.idx(idx_hi)
	);

	tlic_arbiter u_arb_lo (
		.req(req_lo),
		.hit(hit_lo),
		.idx(idx_lo)
	);

	// high preempts low; nothing preempts high; equal level waits
	assign allow_hi = hit_hi & ~insvc_ff[1];
	assign allow_lo = hit_lo & ~insvc_ff[1] & ~insvc_ff[0];
	// a return in this very cycle blocks too, so the hold cannot be skipped
	assign take = (state_ff == ST_IDLE) & ~hold_ff & ~RETURN_DONE
		& (allow_hi | allow_lo);
	assign take_high = allow_hi;
	assign take_idx = allow_hi ? idx_hi : idx_lo;

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	always @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			mask_ff <= `TLIC_MASK_RESET;
			level_ff <= 7'h00;
			xmask_a_ff <= 8'h00;
			xlevel_a_ff <= `TLIC_LEVEL_RESET;
			xmask_b_ff <= 1'b0;
			xlevel_b_ff <= 1'b0;
		end else if (REG_WR) begin
			case (REG_ADDR)
				`TLIC_OFF_MASK: mask_ff <= REG_WDATA;
				`TLIC_OFF_LEVEL: level_ff <= REG_WDATA[6:0];
				`TLIC_OFF_XMASK_A: xmask_a_ff <= REG_WDATA;
				`TLIC_OFF_XLEVEL_A: xlevel_a_ff <= REG_WDATA;
				`TLIC_OFF_XMASK_B: xmask_b_ff <= REG_WDATA[1];
				`TLIC_OFF_XLEVEL_B: xlevel_b_ff <= REG_WDATA[1];
				default: begin
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// pending flags: set wins over clear
	// ------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < `TLIC_NSRC; g = g + 1) begin : g_pend
			wire sw_wr;
			wire sw_val;
			wire hw_clr;
			wire src_ok;
			assign sw_wr = REG_WR & (g < 8 ? REG_ADDR == `TLIC_OFF_PEND_LO :
				g < 16 ? REG_ADDR == `TLIC_OFF_PEND_HI : REG_ADDR == `TLIC_OFF_PEND_X);
			assign sw_val = REG_WDATA[g % 8];
			assign src_ok = SRC_USED[g];
			assign hw_clr = AUTO_CLR[g] & take & (take_idx == g);
			always @(posedge SYS_CLK or negedge RST_N) begin
				if (!RST_N) begin
					pend_ff[g] <= 1'b0;
				end else if (SRC_EVENT[g] & src_ok) begin
					pend_ff[g] <= 1'b1;
				end else if (sw_wr) begin
					pend_ff[g] <= sw_val & src_ok;
				end else if (hw_clr) begin
					pend_ff[g] <= 1'b0;
				end
			end
		end
	endgenerate

	// timer 2 overflow flags, software cleared only
	always @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			t2_low_ff <= 1'b0;
			t2_high_ff <= 1'b0;
		end else begin
			if (T2_LOW_OVF) begin
				t2_low_ff <= 1'b1;
			end else if (REG_WR & (REG_ADDR == `TLIC_OFF_STATUS)) begin
				t2_low_ff <= REG_WDATA[0];
			end
			if (T2_HIGH_OVF) begin
				t2_high_ff <= 1'b1;
			end else if (REG_WR & (REG_ADDR == `TLIC_OFF_STATUS)) begin
				t2_high_ff <= REG_WDATA[1];
			end
		end
	end

	// ------------------------------------------------------------
	// call sequencer
	// ------------------------------------------------------------
	always @* begin
		nxt_state = state_ff;
		nxt_cnt = cnt_ff;
		case (state_ff)
			ST_IDLE: begin
				if (take) begin
					nxt_state = ST_CALL;
					nxt_cnt = 3'h0;
				end
			end
			ST_CALL: begin
				// fetch stall freezes the call count
				if (!FETCH_STALL) begin
					if (cnt_ff == CALL_LAST) begin
						nxt_state = ST_IDLE;
					end else begin
						nxt_cnt = cnt_ff + 3'h1;
					end
				end
			end
			default: begin
				nxt_state = ST_IDLE;
				nxt_cnt = 3'h0;
			end
		endcase
	end

	always @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			state_ff <= ST_IDLE;
			cnt_ff <= 3'h0;
			sel_ff <= 5'h00;
			sel_high_ff <= 1'b0;
			CALL_REQ <= 1'b0;
			CALL_ADDR <= 16'h0000;
			CALL_TAKEN <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			cnt_ff <= nxt_cnt;
			CALL_TAKEN <= take;
			if (take) begin
				sel_ff <= take_idx;
				sel_high_ff <= take_high;
				CALL_REQ <= 1'b1;
				CALL_ADDR <= `TLIC_VEC_BASE + {8'h00, take_idx, 3'h0};
			end else if (state_ff == ST_CALL && !FETCH_STALL && cnt_ff == CALL_LAST) begin
				CALL_REQ <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// in-service levels and post-return hold
	// ------------------------------------------------------------
	always @* begin
		nxt_insvc = insvc_ff;
		if (take) begin
			if (take_high) begin
				nxt_insvc[1] = 1'b1;
			end else begin
				nxt_insvc[0] = 1'b1;
			end
		end else if (RETURN_DONE) begin
			// a return pops only the highest level in service
			if (insvc_ff[1]) begin
				nxt_insvc[1] = 1'b0;
			end else begin
				nxt_insvc[0] = 1'b0;
			end
		end
	end

	always @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			insvc_ff <= 2'b00;
			hold_ff <= 1'b0;
		end else begin
			insvc_ff <= nxt_insvc;
			// one instruction must finish after a return
			if (RETURN_DONE) begin
				hold_ff <= 1'b1;
			end else if (INSTR_DONE) begin
				hold_ff <= 1'b0;
			end
		end
	end

	always @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			IN_SERVICE <= 2'b00;
		end else begin
			// same next value as the internal bits, so the pin never lags a return
			IN_SERVICE <= nxt_insvc;
		end
	end

	// ------------------------------------------------------------
	// read port
	// ------------------------------------------------------------
	always @* begin
		case (REG_ADDR)
			`TLIC_OFF_MASK: nxt_rdata = mask_ff;
			`TLIC_OFF_LEVEL: nxt_rdata = {1'b1, level_ff};
			`TLIC_OFF_XMASK_A: nxt_rdata = xmask_a_ff;
			`TLIC_OFF_XLEVEL_A: nxt_rdata = xlevel_a_ff;
			`TLIC_OFF_XMASK_B: nxt_rdata = {6'h00, xmask_b_ff, 1'b0};
			`TLIC_OFF_XLEVEL_B: nxt_rdata = {6'h00, xlevel_b_ff, 1'b0};
			`TLIC_OFF_PEND_LO: nxt_rdata = pend_eff[7:0];
			`TLIC_OFF_PEND_HI: nxt_rdata = pend_ff[15:8];
			`TLIC_OFF_PEND_X: nxt_rdata = {7'h00, pend_ff[16]};
			`TLIC_OFF_STATUS: nxt_rdata = {hold_ff, sel_high_ff, insvc_ff, 2'b00, t2_high_ff,
				t2_low_ff};
			default: nxt_rdata = 8'h00;
		endcase
	end

	always @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			REG_RDATA <= 8'h00;
		end else if (REG_RD) begin
			REG_RDATA <= nxt_rdata;
		end else begin
			REG_RDATA <= 8'h00;
		end
	end
endmodule
`default_nettype wire

/* sim/tlic_cpu_model.sv */
// behavioural core sequencer facing the interrupt controller
`timescale 1ns/1ps
`default_nettype none
module tlic_cpu_model (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// bench commands and controller call
	input wire logic call_req,
	input wire logic ret_cmd,
	input wire logic slow,
	// core status
	output logic instr_done,
	output logic return_done,
	output logic fetch_stall
);
	logic [1:0] cnt_ff;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_ff <= 2'h0;
			instr_done <= 1'b0;
			return_done <= 1'b0;
			fetch_stall <= 1'b0;
		end else begin
			cnt_ff <= cnt_ff + 2'h1;
			// no instruction retires while the call runs
			instr_done <= !call_req && !ret_cmd && cnt_ff == 2'h3;
			return_done <= ret_cmd;
			// cache miss every other call cycle
			fetch_stall <= slow && call_req && !fetch_stall;
		end
	end
endmodule
`default_nettype wire

/* sim/tlic_chk.sv */
// assertions on the interrupt controller ports
`timescale 1ns/1ps
`default_nettype none
`include "tlic_consts.vh"
module tlic_chk (
	input wire logic SYS_CLK,
	input wire logic RST_N,
	input wire logic [7:0] REG_ADDR,
	input wire logic [7:0] REG_WDATA,
	input wire logic REG_WR,
	input wire logic REG_RD,
	input wire logic [7:0] REG_RDATA,
	input wire logic INSTR_DONE,
	input wire logic RETURN_DONE,
	input wire logic FETCH_STALL,
	input wire logic CALL_REQ,
	input wire logic [15:0] CALL_ADDR,
	input wire logic CALL_TAKEN,
	input wire logic [1:0] IN_SERVICE
);
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (!RST_N);
	logic gate_ff, wait_ff;
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			gate_ff <= 1'b0;
			wait_ff <= 1'b0;
		end else begin
			if (REG_WR && REG_ADDR == `TLIC_OFF_MASK) gate_ff <= REG_WDATA[`TLIC_GATE_BIT];
			wait_ff <= RETURN_DONE | (wait_ff & !INSTR_DONE);
		end
	end
	property p_hold; CALL_TAKEN |-> CALL_REQ [*4]; endproperty
	a_hold: assert property (p_hold) else $error("call shorter than four cycles");
	property p_len; CALL_TAKEN ##0 !FETCH_STALL [*4] |=> !CALL_REQ; endproperty
	a_len: assert property (p_len) else $error("call longer than four cycles");
	property p_one; CALL_TAKEN |=> !CALL_TAKEN; endproperty
	a_one: assert property (p_one) else $error("second take during call");
	property p_vec; CALL_TAKEN |-> CALL_ADDR[2:0] == 3'h3 && CALL_ADDR <= 16'h0083
		&& CALL_ADDR != 16'h0043 && CALL_ADDR != 16'h007B; endproperty
	a_vec: assert property (p_vec) else $error("bad vector address");
	property p_hi; $past(IN_SERVICE[1]) |-> !CALL_TAKEN; endproperty
	a_hi: assert property (p_hi) else $error("take during high routine");
	property p_gate; !gate_ff && !$past(gate_ff) |-> !CALL_TAKEN; endproperty
	a_gate: assert property (p_gate) else $error("take with gate off");
	property p_wait; wait_ff && $past(wait_ff) |-> !CALL_TAKEN; endproperty
	a_wait: assert property (p_wait) else $error("take before next instruction");
	property p_isv; CALL_TAKEN |-> IN_SERVICE != 2'h0; endproperty
	a_isv: assert property (p_isv) else $error("no level in service");
	property p_pop; RETURN_DONE && IN_SERVICE == 2'h3 |=> IN_SERVICE == 2'h1; endproperty
	a_pop: assert property (p_pop) else $error("return cleared wrong level");
	property p_rd; !$past(REG_RD) |-> REG_RDATA == 8'h00; endproperty
	a_rd: assert property (p_rd) else $error("read data outside slot");
	c_nest: cover property (CALL_TAKEN && IN_SERVICE == 2'h3);
	c_ret: cover property (RETURN_DONE);
	c_stall: cover property (FETCH_STALL && CALL_REQ);
endmodule
bind tlic_top tlic_chk u_chk (.SYS_CLK(SYS_CLK), .RST_N(RST_N), .REG_ADDR(REG_ADDR),
	.REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
	.INSTR_DONE(INSTR_DONE), .RETURN_DONE(RETURN_DONE), .FETCH_STALL(FETCH_STALL),
	.CALL_REQ(CALL_REQ), .CALL_ADDR(CALL_ADDR), .CALL_TAKEN(CALL_TAKEN),
	.IN_SERVICE(IN_SERVICE));
`default_nettype wire

/* sim/tb_top.sv */
// testbench for the interrupt controller
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic SYS_CLK, RST_N, REG_WR = 0, REG_RD = 0, T2_LOW_OVF = 0, T2_HIGH_OVF = 0;
	logic [7:0] REG_ADDR = 0, REG_WDATA = 0, REG_RDATA;
	logic [16:0] SRC_EVENT = 0;
	logic INSTR_DONE, RETURN_DONE, FETCH_STALL, CALL_REQ, CALL_TAKEN, ret_cmd = 0, slow = 0;
	logic [15:0] CALL_ADDR;
	logic [1:0] IN_SERVICE;
	int err_count = 0, cmp_count = 0, n;
	tlic_top dut (.SYS_CLK(SYS_CLK), .RST_N(RST_N), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
		.REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .SRC_EVENT(SRC_EVENT),
		.T2_LOW_OVF(T2_LOW_OVF), .T2_HIGH_OVF(T2_HIGH_OVF), .INSTR_DONE(INSTR_DONE),
		.RETURN_DONE(RETURN_DONE), .FETCH_STALL(FETCH_STALL), .CALL_REQ(CALL_REQ),
		.CALL_ADDR(CALL_ADDR), .CALL_TAKEN(CALL_TAKEN), .IN_SERVICE(IN_SERVICE));
	tlic_cpu_model cpu (.clk(SYS_CLK), .rst_n(RST_N), .call_req(CALL_REQ), .ret_cmd(ret_cmd),
		.slow(slow), .instr_done(INSTR_DONE), .return_done(RETURN_DONE),
		.fetch_stall(FETCH_STALL));
	// ----------------
	// access tasks
	// ----------------
	task chk(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge SYS_CLK);
		REG_ADDR <= a;
		REG_WDATA <= d;
		REG_WR <= 1'b1;
		@(posedge SYS_CLK);
		REG_WR <= 1'b0;
	endtask
	task rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge SYS_CLK);
		REG_ADDR <= a;
		REG_RD <= 1'b1;
		@(posedge SYS_CLK);
		REG_RD <= 1'b0;
		#1 chk({8'h00, REG_RDATA}, {8'h00, exp});
	endtask
	task ev(input logic [16:0] s);
		@(posedge SYS_CLK);
		SRC_EVENT <= s;
		@(posedge SYS_CLK);
		SRC_EVENT <= 17'h0;
	endtask
	// bounded wait for the take, then count call cycles
	task call(input logic [15:0] a);
		// the take may land on the edge at which the previous task returned
		#1 n = 0;
		while (CALL_TAKEN !== 1'b1 && n < 40) begin
			@(posedge SYS_CLK);
			#1 n++;
		end
		chk({15'h0, CALL_TAKEN}, 16'h1);
		chk(CALL_ADDR, a);
		n = 0;
		while (CALL_REQ === 1'b1 && n < 20) begin
			@(posedge SYS_CLK);
			#1 n++;
		end
	endtask
	task ret;
		@(posedge SYS_CLK);
		ret_cmd <= 1'b1;
		@(posedge SYS_CLK);
		ret_cmd <= 1'b0;
		repeat (3) @(posedge SYS_CLK);
	endtask
	task stop_test;
		$display("compares %0d, wrong %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		SYS_CLK = 0;
		forever #4 SYS_CLK = ~SYS_CLK;
	end
	initial begin
		repeat (5000) @(posedge SYS_CLK);
		err_count++;
		stop_test;
	end
	// ----------------
	// tests
	// ----------------
	initial begin
		RST_N = 0;
		repeat (20) @(posedge SYS_CLK);
		RST_N <= 1'b1;
		rd(8'hA8, 8'h00);
		rd(8'hB8, 8'h80);
		rd(8'h10, 8'h00);
		chk(CALL_ADDR, 16'h0000);
		$display("test reset done");
		wr(8'hA8, 8'h7F);
		ev(17'h00001);
		repeat (10) @(posedge SYS_CLK);
		#1 chk({15'h0, CALL_REQ}, 16'h0);
		rd(8'hC0, 8'h01);
		wr(8'hA8, 8'hFF);
		call(16'h0003);
		chk(n, 4);
		rd(8'hC0, 8'h00);
		ret;
		$display("test gate done");
		wr(8'hB8, 8'h10);
		ev(17'h00012);
		call(16'h0023);
		chk(IN_SERVICE, 2'h2);
		rd(8'hC0, 8'h12);
		wr(8'hC0, 8'h02);
		ret;
		call(16'h000B);
		ev(17'h00010);
		call(16'h0023);
		chk(IN_SERVICE, 2'h3);
		wr(8'hC0, 8'h00);
		ret;
		ret;
		chk(IN_SERVICE, 2'h0);
		$display("test levels done");
		@(posedge SYS_CLK);
		T2_HIGH_OVF <= 1'b1;
		@(posedge SYS_CLK);
		T2_HIGH_OVF <= 1'b0;
		call(16'h002B);
		ret;
		call(16'h002B);
		wr(8'hC3, 8'h00);
		@(posedge SYS_CLK);
		T2_LOW_OVF <= 1'b1;
		@(posedge SYS_CLK);
		T2_LOW_OVF <= 1'b0;
		rd(8'hC0, 8'h20);
		wr(8'hC3, 8'h00);
		ret;
		slow <= 1'b1;
		wr(8'hE7, 8'h02);
		wr(8'hC2, 8'h01);
		call(16'h0083);
		chk(n > 4, 1);
		wr(8'hC2, 8'h00);
		ret;
		$display("test extended done");
		stop_test;
	end
endmodule
`default_nettype wire
